/* File: uart_rx_consts.vh */
`ifndef UART_RX_CONSTS_VH
`define UART_RX_CONSTS_VH

// Register addresses
`define ADDR_ASYNC_MODE 16'hff70
`define ADDR_ERR_STATUS 16'hff71
`define ADDR_SYNC_MODE 16'hff72
`define ADDR_BAUD_CTRL 16'hff73
`define ADDR_RX_BUFFER 16'hff74

// Reset values
`define RST_ASYNC_MODE 8'h00
`define RST_SYNC_MODE 8'h00
`define RST_BAUD_CTRL 8'h00

// Async mode register fields
`define AM_TX_EN 7
`define AM_RX_EN 6
`define AM_PAR_HI 5
`define AM_PAR_LO 4
`define AM_CHAR8 3
`define AM_STOP2 2

// Sync mode register fields
`define SM_ENABLE 7
`define SM_BIT_ORDER 2
`define SM_CLK_SEL 1
`define SM_WRITE_MASK 8'h86

// Parity modes
`define PAR_NONE 2'b00
`define PAR_ZERO 2'b01
`define PAR_ODD 2'b10
`define PAR_EVEN 2'b11

// Error status codes
`define ERR_PARITY 8'h04
`define ERR_FRAMING 8'h02
`define ERR_OVERRUN 8'h01

// Baud control: source select field and the external clock code
`define BRG_SEL_HI 7
`define BRG_SEL_LO 4
`define BRG_SEL_EXT 4'h8

// Receive timing in serial clock ticks
`define TICKS_PER_BIT 3'h7
`define TICKS_HALF_BIT 3'h3

`endif

/* File: uart_rx_path.v */
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_consts.vh"

module uart_rx_path #(
  parameter DATA_W = 8
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Register port
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Serial pins
  input wire rx_line_pin,
  input wire ext_baud_pin,
  // Transmit side events
  input wire tx_done,
  input wire tx_irq_flag_clr,
  // Interrupts and flags
  output reg rx_complete_irq,
  output reg tx_complete_irq,
  output reg tx_irq_request_flag,
  // Mode outputs
  output reg tx_enable_bit,
  output reg sync_enable_bit,
  output reg bit_order_select,
  output reg sync_clock_select,
  // Received word stream
  output reg rx_word_valid,
  input wire rx_word_ready,
  output reg [DATA_W+2:0] rx_word
);

  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA = 3'd2;
  localparam ST_PARITY = 3'd3;
  localparam ST_STOP = 3'd4;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] async_mode_r;
  reg [7:0] sync_mode_r;
  reg [7:0] baud_ctrl_r;
  reg [7:0] rx_buffer_r;
  reg [7:0] rx_error_status_r;
  reg buf_unread_r;

  wire wr_async = reg_wr && (reg_addr == `ADDR_ASYNC_MODE);
  wire wr_sync = reg_wr && (reg_addr == `ADDR_SYNC_MODE);
  wire wr_baud = reg_wr && (reg_addr == `ADDR_BAUD_CTRL);
  wire rd_buffer = reg_rd && (reg_addr == `ADDR_RX_BUFFER);

  wire rx_en = async_mode_r[`AM_RX_EN];
  wire [1:0] par_mode = async_mode_r[`AM_PAR_HI:`AM_PAR_LO];
  wire char8 = async_mode_r[`AM_CHAR8];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree

  reg [2:0] rx_sync_r;
  reg rx_level_r;
  reg [2:0] ext_sync_r;
  reg ext_level_r;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_sync_r <= 3'h7;
      rx_level_r <= 1'b1;
      ext_sync_r <= 3'h0;
      ext_level_r <= 1'b0;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], rx_line_pin};
      if (rx_sync_r[1] == rx_sync_r[2])
        rx_level_r <= rx_sync_r[2];
      ext_sync_r <= {ext_sync_r[1:0], ext_baud_pin};
      if (ext_sync_r[1] == ext_sync_r[2])
        ext_level_r <= ext_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator: serial clock is the source clock halved, eight per bit

  reg [8:0] presc_r;
  reg ext_prev_r;
  reg ext_half_r;
  wire [3:0] brg_sel = baud_ctrl_r[`BRG_SEL_HI:`BRG_SEL_LO];
  wire [8:0] presc_mask = ~(9'h1ff << ({1'b0, brg_sel[2:0]} + 4'h2));
  wire ext_rise = ext_level_r && !ext_prev_r;
  wire int_tick = !brg_sel[3] && ((presc_r & presc_mask) == presc_mask);
  // Two external rising edges make one tick, matching the internal halving
  wire ext_tick = (brg_sel == `BRG_SEL_EXT) && ext_rise && ext_half_r;
  wire serial_tick = int_tick || ext_tick;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      presc_r <= 9'h000;
      ext_prev_r <= 1'b0;
      ext_half_r <= 1'b0;
    end else begin
      presc_r <= presc_r + 9'h001;
      ext_prev_r <= ext_level_r;
      if (ext_rise)
        ext_half_r <= !ext_half_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive state machine

  reg [2:0] state_r;
  reg [2:0] tick_cnt_r;
  reg [2:0] bit_idx_r;
  reg [7:0] shift_r;
  reg par_bit_r;
  reg frame_done_r;
  reg irq_pending_r;

  wire bit_point = serial_tick && (tick_cnt_r == `TICKS_PER_BIT);
  wire [2:0] last_idx = char8 ? 3'd7 : 3'd6;
  wire ones_odd = (^shift_r) ^ par_bit_r;
  wire parity_err = (par_mode == `PAR_EVEN) ? ones_odd :
                    (par_mode == `PAR_ODD) ? !ones_odd : 1'b0;
  wire stop_point = (state_r == ST_STOP) && bit_point;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      tick_cnt_r <= 3'h0;
      bit_idx_r <= 3'h0;
      shift_r <= 8'h00;
      par_bit_r <= 1'b0;
    end else if (!rx_en) begin
      // Immediate abort; buffer and status stay as they were
      state_r <= ST_IDLE;
      tick_cnt_r <= 3'h0;
    end else begin
      if (serial_tick)
        tick_cnt_r <= tick_cnt_r + 3'h1;
      case (state_r)
        ST_IDLE: begin
          if (!rx_level_r) begin
            state_r <= ST_START;
            tick_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            bit_idx_r <= 3'h0;
          end
        end
        ST_START: begin
          if (serial_tick && (tick_cnt_r == `TICKS_HALF_BIT)) begin
            // A glitch shorter than half a bit falls back to idle
            if (rx_level_r) begin
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_DATA;
              tick_cnt_r <= 3'h0;
            end
          end
        end
        ST_DATA: begin
          if (bit_point) begin
            shift_r[bit_idx_r] <= rx_level_r;
            bit_idx_r <= bit_idx_r + 3'h1;
            if (bit_idx_r == last_idx)
              state_r <= (par_mode == `PAR_NONE) ? ST_STOP : ST_PARITY;
          end
        end
        ST_PARITY: begin
          if (bit_point) begin
            par_bit_r <= rx_level_r;
            state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          // A second stop bit is never waited for
          if (bit_point)
            state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion, error status and buffer

  wire [7:0] err_code = (parity_err ? `ERR_PARITY : 8'h00) |
                        (!rx_level_r ? `ERR_FRAMING : 8'h00) |
                        (buf_unread_r ? `ERR_OVERRUN : 8'h00);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_buffer_r <= 8'h00;
      rx_error_status_r <= 8'h00;
      buf_unread_r <= 1'b0;
      frame_done_r <= 1'b0;
      irq_pending_r <= 1'b0;
      rx_complete_irq <= 1'b0;
    end else begin
      frame_done_r <= 1'b0;
      irq_pending_r <= 1'b0;
      // Disabling between buffer load and interrupt drops only the interrupt
      rx_complete_irq <= irq_pending_r && rx_en;
      if (stop_point && rx_en) begin
        rx_buffer_r <= shift_r;
        rx_error_status_r <= err_code;
        buf_unread_r <= 1'b1;
        frame_done_r <= 1'b1;
        irq_pending_r <= 1'b1;
      end else if (rd_buffer) begin
        // A completion in the same cycle wins over the read
        rx_error_status_r <= 8'h00;
        buf_unread_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer towards the word consumer; drops only when both full

  reg [DATA_W+2:0] fifo_mem_r [0:1];
  reg [1:0] fifo_cnt_r;
  reg fifo_rd_ptr_r;
  reg fifo_wr_ptr_r;
  // A third word is lost here but still stands in the buffer register
  wire fifo_push = frame_done_r && (fifo_cnt_r != 2'd2);
  wire fifo_pop = rx_word_valid && rx_word_ready;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_mem_r[0] <= {(DATA_W+3){1'b0}};
      fifo_mem_r[1] <= {(DATA_W+3){1'b0}};
      fifo_cnt_r <= 2'd0;
      fifo_rd_ptr_r <= 1'b0;
      fifo_wr_ptr_r <= 1'b0;
      rx_word_valid <= 1'b0;
      rx_word <= {(DATA_W+3){1'b0}};
    end else begin
      if (fifo_push) begin
        fifo_mem_r[fifo_wr_ptr_r] <= {rx_error_status_r[2:0], rx_buffer_r[DATA_W-1:0]};
        fifo_wr_ptr_r <= !fifo_wr_ptr_r;
      end
      if (fifo_pop)
        fifo_rd_ptr_r <= !fifo_rd_ptr_r;
      fifo_cnt_r <= fifo_cnt_r + {1'b0, fifo_push} - {1'b0, fifo_pop};
      if (!rx_word_valid || fifo_pop) begin
        if (fifo_cnt_r > {1'b0, fifo_pop}) begin
          rx_word_valid <= 1'b1;
          rx_word <= fifo_mem_r[fifo_rd_ptr_r ^ fifo_pop];
        end else if (fifo_push) begin
          rx_word_valid <= 1'b1;
          rx_word <= {rx_error_status_r[2:0], rx_buffer_r[DATA_W-1:0]};
        end else begin
          rx_word_valid <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, transmit flag, reads

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      async_mode_r <= `RST_ASYNC_MODE;
      sync_mode_r <= `RST_SYNC_MODE;
      baud_ctrl_r <= `RST_BAUD_CTRL;
      tx_complete_irq <= 1'b0;
      tx_irq_request_flag <= 1'b0;
      tx_enable_bit <= 1'b0;
      sync_enable_bit <= 1'b0;
      bit_order_select <= 1'b0;
      sync_clock_select <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      if (wr_async)
        async_mode_r <= {reg_wdata[7:2], 2'b00};
      if (wr_sync)
        sync_mode_r <= reg_wdata & `SM_WRITE_MASK;
      // A baud change mid-frame shifts the tick grid; change it only when idle
      if (wr_baud)
        baud_ctrl_r <= {reg_wdata[7:4], 4'h0};
      tx_complete_irq <= tx_done;
      if (tx_done)
        tx_irq_request_flag <= 1'b1;
      else if (tx_irq_flag_clr)
        tx_irq_request_flag <= 1'b0;
      tx_enable_bit <= async_mode_r[`AM_TX_EN];
      // Three-wire logic elsewhere is held idle while this is low
      sync_enable_bit <= sync_mode_r[`SM_ENABLE];
      bit_order_select <= sync_mode_r[`SM_BIT_ORDER];
      sync_clock_select <= sync_mode_r[`SM_CLK_SEL];
      // The receive buffer is read-only; a write to its address is ignored
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_ASYNC_MODE: reg_rdata <= async_mode_r;
          `ADDR_ERR_STATUS: reg_rdata <= rx_error_status_r;
          `ADDR_SYNC_MODE: reg_rdata <= sync_mode_r;
          `ADDR_BAUD_CTRL: reg_rdata <= baud_ctrl_r;
          `ADDR_RX_BUFFER: reg_rdata <= rx_buffer_r;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: HANDOVER_END_UNUSED.v */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: uart_rx_path_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_consts.vh"
module uart_rx_path_chk #(
  parameter DATA_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Events and mode copies
  input wire logic tx_done,
  input wire logic tx_irq_flag_clr,
  input wire logic tx_complete_irq,
  input wire logic tx_irq_request_flag,
  input wire logic rx_complete_irq,
  input wire logic sync_enable_bit,
  input wire logic bit_order_select,
  // Received word stream
  input wire logic rx_word_valid,
  input wire logic rx_word_ready,
  input wire logic [DATA_W+2:0] rx_word
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  sequence rd_buf;
    reg_rd && reg_addr == `ADDR_RX_BUFFER;
  endsequence
  sequence rd_stat;
    reg_rd && reg_addr == `ADDR_ERR_STATUS;
  endsequence
  wire sync_wr = reg_wr && reg_addr == `ADDR_SYNC_MODE;
  ////////////////////////////////////////////////////////////////
  irq_one_cycle_a: assert property (rx_complete_irq |=> !rx_complete_irq)
    else $error("receive irq wider than one cycle");
  irq_word_push_a: assert property (rx_complete_irq |-> rx_word_valid)
    else $error("completed frame gave no stream word");
  word_hold_a: assert property (
    rx_word_valid && !rx_word_ready |=> rx_word_valid && $stable(rx_word))
    else $error("stalled word changed or vanished");
  status_clear_a: assert property (rd_buf ##2 rd_stat |=>
    reg_rdata == 8'h00 || rx_complete_irq || $past(rx_complete_irq))
    else $error("status not cleared by buffer read");
  sync_copy_a: assert property (sync_wr ##1 !sync_wr |=>
    sync_enable_bit == $past(reg_wdata[7], 2) && bit_order_select == $past(reg_wdata[2], 2))
    else $error("sync mode copies wrong");
  sync_reserved_a: assert property (reg_rd && reg_addr == `ADDR_SYNC_MODE |=>
    (reg_rdata & ~`SM_WRITE_MASK) == 8'h00)
    else $error("sync mode reserved bits not zero");
  tx_irq_flag_a: assert property (tx_done |=> tx_complete_irq && tx_irq_request_flag)
    else $error("tx completion did not raise irq and flag");
  tx_flag_hold_a: assert property (tx_irq_request_flag && !tx_irq_flag_clr |=>
    tx_irq_request_flag)
    else $error("tx request flag dropped without clear");
endmodule
bind uart_rx_path uart_rx_path_chk #(.DATA_W(DATA_W)) u_chk (.core_clk, .resetn, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tx_done, .tx_irq_flag_clr, .tx_complete_irq,
  .tx_irq_request_flag, .rx_complete_irq, .sync_enable_bit, .bit_order_select,
  .rx_word_valid, .rx_word_ready, .rx_word);
`default_nettype wire

/* File: uart_far_tx.sv */
`timescale 1ns/100ps
`default_nettype none
module uart_far_tx #(
  parameter real BIT_NS = 1280.0
) (
  // Serial line toward the receiver
  output var logic line
);
  initial line = 1'b1;
  // pm: 0 none, 1 zero, 2 odd, 3 even; flip corrupts the parity bit
  task automatic send(input logic [7:0] d, input int nb, input int pm, input logic flip,
                      input logic stop);
    logic p;
    p = (nb == 7 ? ^d[6:0] : ^d) ^ (pm == 2) ^ flip;
    if (pm == 1) p = flip;
    line = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < nb; i++) begin
      line = d[i];
      #(BIT_NS);
    end
    if (pm != 0) begin
      line = p;
      #(BIT_NS);
    end
    line = stop;
    // A low stop is cut short so the line is high again before any half-bit recheck
    #(stop ? BIT_NS : BIT_NS * 0.7);
    line = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_consts.vh"
module tb_top;
  logic core_clk, resetn, reg_wr, reg_rd, tx_done, tx_irq_flag_clr, rx_word_ready;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  wire logic rx_line, line_int, line_ext;
  logic ext_baud;
  logic rx_complete_irq, tx_complete_irq, tx_irq_request_flag, tx_enable_bit;
  logic sync_enable_bit, bit_order_select, sync_clock_select, rx_word_valid;
  logic [10:0] rx_word;
  logic [10:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  int irq_cnt = 0;
  int irq_n;
  logic [7:0] tm[7] = '{8'h78, 8'h78, 8'h68, 8'h58, 8'h48, 8'h40, 8'h68};
  logic [7:0] td[7] = '{8'ha5, 8'h3c, 8'h81, 8'h5a, 8'h96, 8'hff, 8'h0f};
  logic [7:0] te[7] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h02, 8'h00, 8'h06};
  logic tf[7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic ts[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  uart_rx_path #(.DATA_W(8)) u_dut (.core_clk, .resetn, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .rx_line_pin(rx_line), .ext_baud_pin(ext_baud), .tx_done,
    .tx_irq_flag_clr, .rx_complete_irq, .tx_complete_irq, .tx_irq_request_flag,
    .tx_enable_bit, .sync_enable_bit, .bit_order_select, .sync_clock_select,
    .rx_word_valid, .rx_word_ready, .rx_word);
  uart_far_tx u_far (.line(line_int));
  uart_far_tx #(.BIT_NS(2560.0)) u_far_ext (.line(line_ext));
  assign rx_line = line_int & line_ext;
  ////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task wait_irq;
    int n;
    n = 0;
    while (rx_complete_irq !== 1'b1 && n < 1200) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(rx_complete_irq, 1'b1);
  endtask
  task frame(input logic [7:0] m, d, input logic fl, sb, input logic [7:0] st, dx);
    wr(`ADDR_ASYNC_MODE, m);
    exp_q.push_back({st[2:0], dx});
    fork
      u_far.send(d, m[3] ? 8 : 7, int'(m[5:4]), fl, sb);
      wait_irq();
    join
  endtask
  task final_report;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (rx_complete_irq === 1'b1) irq_cnt++;
    if (rx_word_valid === 1'b1 && rx_word_ready === 1'b1) chk(rx_word, exp_q.pop_front());
  end
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // External baud source: four core cycles per period, so the pin synchroniser can follow it
  initial begin
    ext_baud = 1'b0;
    forever begin
      repeat (2) @(posedge core_clk);
      #1 ext_baud = ~ext_baud;
    end
  end
  initial begin
    #1_000_000 num_errors++;
    final_report();
  end
  initial begin
    resetn = 1'b0;
    {reg_wr, reg_rd, tx_done, tx_irq_flag_clr, reg_addr, reg_wdata} = '0;
    rx_word_ready = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    for (int a = 16'hff70; a <= 16'hff75; a++) rd(a[15:0], 8'h00);
    wr(`ADDR_SYNC_MODE, 8'h86);
    rd(`ADDR_SYNC_MODE, 8'h86);
    chk({sync_enable_bit, bit_order_select, sync_clock_select}, 3'b111);
    wr(`ADDR_SYNC_MODE, 8'h00);
    rd(`ADDR_SYNC_MODE, 8'h00);
    chk({sync_enable_bit, bit_order_select, sync_clock_select}, 3'b000);
    wr(`ADDR_BAUD_CTRL, 8'hff);
    rd(`ADDR_BAUD_CTRL, 8'hf0);
    wr(`ADDR_BAUD_CTRL, 8'h00);
    wr(`ADDR_ASYNC_MODE, 8'h80);
    rd(`ADDR_ASYNC_MODE, 8'h80);
    chk(tx_enable_bit, 1'b1);
    // Mode is rewritten here while no transmission runs
    wr(`ADDR_ASYNC_MODE, 8'h00);
    rd(`ADDR_ASYNC_MODE, 8'h00);
    chk(tx_enable_bit, 1'b0);
    @(posedge core_clk);
    #1 tx_done = 1'b1;
    @(posedge core_clk);
    #1 tx_done = 1'b0;
    chk({tx_irq_request_flag, tx_complete_irq}, 2'b11);
    tx_irq_flag_clr = 1'b1;
    @(posedge core_clk);
    #1 tx_irq_flag_clr = 1'b0;
    chk({tx_irq_request_flag, tx_complete_irq}, 2'b00);
    for (int i = 0; i < 7; i++) begin
      frame(tm[i], td[i], tf[i], ts[i], te[i], tm[i][3] ? td[i] : {1'b0, td[i][6:0]});
      rd(`ADDR_ERR_STATUS, te[i]);
      rd(`ADDR_RX_BUFFER, tm[i][3] ? td[i] : {1'b0, td[i][6:0]});
      rd(`ADDR_ERR_STATUS, 8'h00);
    end
    // External baud source: two pin rises per serial tick, bit twice as long
    wr(`ADDR_ASYNC_MODE, 8'h48);
    wr(`ADDR_BAUD_CTRL, 8'h80);
    exp_q.push_back({3'h0, 8'hc3});
    fork
      u_far_ext.send(8'hc3, 8, 0, 1'b0, 1'b1);
      wait_irq();
    join
    rd(`ADDR_ERR_STATUS, 8'h00);
    rd(`ADDR_RX_BUFFER, 8'hc3);
    wr(`ADDR_BAUD_CTRL, 8'h00);
    // Stall the stream and skip buffer reads: later frames overrun, third word is dropped
    rx_word_ready = 1'b0;
    frame(8'h48, 8'h11, 1'b0, 1'b1, 8'h00, 8'h11);
    frame(8'h48, 8'h22, 1'b0, 1'b1, 8'h01, 8'h22);
    frame(8'h48, 8'h33, 1'b0, 1'b1, 8'h01, 8'h33);
    exp_q.delete(exp_q.size() - 1);
    irq_n = irq_cnt;
    fork
      u_far.send(8'h77, 8, 0, 1'b0, 1'b1);
      #6400 wr(`ADDR_ASYNC_MODE, 8'h08);
    join
    chk(irq_cnt[15:0], irq_n[15:0]);
    rd(`ADDR_ERR_STATUS, 8'h01);
    rd(`ADDR_RX_BUFFER, 8'h33);
    rx_word_ready = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk(rx_word_valid, 1'b0);
    chk(exp_q.size(), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
